// ### include/srr_pkg.sv
// Shared constants for the shadow-registered one-time-programmable memory
`default_nettype none
package srr_pkg;
   localparam int unsigned ADDR_W      = 12;
   localparam int unsigned DATA_W      = 4;
   localparam int unsigned WORDS       = 4096;
   localparam logic [3:0]  SHADOW_RST  = 4'h0;
   localparam logic [3:0]  OUTREG_RST  = 4'h0;
   localparam logic [3:0]  BLANK_WORD  = 4'h0;
   localparam int unsigned MSB_POS     = DATA_W - 1;
endpackage
`default_nettype wire

// ### core/srr_fuse_mem.sv
// Fuse array: 4096 by 4 bits, bits may only go from low to high, registered read
`default_nettype none
module srr_fuse_mem
   import srr_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_rst_b,
   input  wire logic [ADDR_W-1:0] i_addr,
   output logic      [DATA_W-1:0] o_rdata,
   input  wire logic              i_prog_en,
   input  wire logic [ADDR_W-1:0] i_prog_addr,
   input  wire logic [DATA_W-1:0] i_prog_bits
);
   logic [DATA_W-1:0] mem_reg [WORDS];
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;
   logic [DATA_W-1:0] word_next;

   always_comb begin
      rdata_next = mem_reg[i_addr];
      word_next  = mem_reg[i_prog_addr] | i_prog_bits;
   end

   // Fuses are non-volatile, so reset leaves the array alone; only the read register clears
   always_ff @(posedge i_clk) begin
      if (i_prog_en) begin
         mem_reg[i_prog_addr] <= word_next;
      end
   end

   initial begin
      for (int i = 0; i < WORDS; i++) begin
         mem_reg[i] = BLANK_WORD;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rdata_reg <= BLANK_WORD;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign o_rdata = rdata_reg;
endmodule
`default_nettype wire

// ### core/srr_rom.sv
// Shadow-registered fuse memory: output register, shadow register and scan path
// What this block does
// - The array holds 4096 words of 4 bits, each picked by the address for the output register.
// - A 4-bit shadow register stands beside the output register.
// - Shadow register activity never alters the output register.
// - The shadow register changes only on a shadow clock rising edge, from the output bus or serial input.
// - The shadow register can load in parallel from the data pins, floated (outside data) or driven (output register).
// - Mode picks whether the output register loads from the array or from the shadow register.
// - The output register captures only on an output load clock rising edge and holds otherwise.
// - Observation: load array word, parallel-load it into shadow, shift it out serially.
// - Control: shift test data into shadow, then transfer it into the output register.
// - Unprogrammed bits read low.
// - A programmed bit reads high forever.
// - Mode high: serial input high holds the shadow; low loads it from the data bus.
// - Mode low: each shadow clock edge shifts, serial input entering at the LSB.
// - Scan out is the shadow MSB in mode low and the serial input in mode high.
// - Output gate high floats the pins for external data; low drives the output register.
`default_nettype none
module srr_rom
   import srr_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_rst_b,
   input  wire logic [ADDR_W-1:0] i_word_select,
   input  wire logic              i_mode,
   input  wire logic              i_output_load_clock,
   input  wire logic              i_shadow_shift_clock,
   input  wire logic              i_scan_serial_in,
   input  wire logic              i_out_gate_b,
   input  wire logic [DATA_W-1:0] i_data_pins,
   output logic      [DATA_W-1:0] o_data_pins,
   output logic      [DATA_W-1:0] o_data_pins_oe,
   output logic                   o_scan_serial_out,
   input  wire logic              i_prog_en,
   input  wire logic [ADDR_W-1:0] i_prog_addr,
   input  wire logic [DATA_W-1:0] i_prog_bits
);
   typedef enum logic [1:0] {
      OR_HOLD,
      OR_ARRAY,
      OR_SHADOW
   } srr_out_act_t;

   typedef enum logic [1:0] {
      SH_HOLD,
      SH_SHIFT,
      SH_BUS
   } srr_shadow_act_t;

   logic [DATA_W-1:0] array_word;
   logic              output_load_clock_d_reg;
   logic              output_load_clock_d_next;
   logic              shadow_shift_clock_d_reg;
   logic              shadow_shift_clock_d_next;
   logic              or_rise;
   logic              sr_rise;
   srr_out_act_t      out_act;
   srr_shadow_act_t   shadow_act;
   logic [DATA_W-1:0] out_reg;
   logic [DATA_W-1:0] out_next;
   logic [DATA_W-1:0] shadow_reg;
   logic [DATA_W-1:0] shadow_next;
   logic [DATA_W-1:0] bus_word;
   logic              sdo_reg;
   logic              sdo_next;
   logic [DATA_W-1:0] oe_reg;
   logic [DATA_W-1:0] oe_next;

   // A clock input counts as risen when high now and low at the previous i_clk sample
   function automatic logic rise_of(input logic now_lvl, input logic last_lvl);
      return now_lvl & ~last_lvl;
   endfunction

   // Serial entry at the LSB; the MSB moves toward the scan output
   function automatic logic [DATA_W-1:0] shift_in(input logic [DATA_W-1:0] word, input logic bit_in);
      return {word[MSB_POS-1:0], bit_in};
   endfunction

   // Pin level as the shadow sees it: outside data when floated, the output register when driven
   function automatic logic [DATA_W-1:0] pin_level(input logic              gate_b,
                                                   input logic [DATA_W-1:0] ext_word,
                                                   input logic [DATA_W-1:0] own_word);
      return gate_b ? ext_word : own_word;
   endfunction

   // Registered read: the array word lags the address by one i_clk edge
   srr_fuse_mem u_mem (
      .i_clk       (i_clk),
      .i_rst_b     (i_rst_b),
      .i_addr      (i_word_select),
      .o_rdata     (array_word),
      .i_prog_en   (i_prog_en),
      .i_prog_addr (i_prog_addr),
      .i_prog_bits (i_prog_bits)
   );

   // Edge detection of the two slow clock inputs
   always_comb begin
      output_load_clock_d_next = i_output_load_clock;
      shadow_shift_clock_d_next = i_shadow_shift_clock;
      or_rise      = rise_of(i_output_load_clock, output_load_clock_d_reg);
      sr_rise      = rise_of(i_shadow_shift_clock, shadow_shift_clock_d_reg);
   end

   // Detectors reset low, so a clock input already high at release counts as an edge
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         output_load_clock_d_reg <= 1'b0;
         shadow_shift_clock_d_reg <= 1'b0;
      end else begin
         output_load_clock_d_reg <= output_load_clock_d_next;
         shadow_shift_clock_d_reg <= shadow_shift_clock_d_next;
      end
   end

   // Output register: the shadow clock has no path into this decode
   always_comb begin
      out_act = OR_HOLD;
      if (or_rise) begin
         out_act = i_mode ? OR_SHADOW : OR_ARRAY;
      end
      case (out_act)
         OR_ARRAY: begin
            out_next = array_word;
         end
         OR_SHADOW: begin
            out_next = shadow_reg;
         end
         OR_HOLD: begin
            out_next = out_reg;
         end
         default: begin
            out_next = out_reg;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         out_reg <= OUTREG_RST;
      end else begin
         out_reg <= out_next;
      end
   end

   // Shadow register; with mode high and serial input low it takes the bus, which carries out_reg when driven
   always_comb begin
      bus_word    = pin_level(i_out_gate_b, i_data_pins, out_reg);
      shadow_act  = SH_HOLD;
      if (sr_rise) begin
         if (!i_mode) begin
            shadow_act = SH_SHIFT;
         end else if (!i_scan_serial_in) begin
            shadow_act = SH_BUS;
         end
      end
      case (shadow_act)
         SH_SHIFT: begin
            shadow_next = shift_in(shadow_reg, i_scan_serial_in);
         end
         SH_BUS: begin
            shadow_next = bus_word;
         end
         SH_HOLD: begin
            shadow_next = shadow_reg;
         end
         default: begin
            shadow_next = shadow_reg;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         shadow_reg <= SHADOW_RST;
      end else begin
         shadow_reg <= shadow_next;
      end
   end

   // Scan out is registered so every output leaves a flip-flop; one i_clk of lag in mode high only, as mode low takes shadow_next
   always_comb begin
      sdo_next = i_mode ? i_scan_serial_in : shadow_next[MSB_POS];
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sdo_reg <= 1'b0;
      end else begin
         sdo_reg <= sdo_next;
      end
   end

   // Pin enables follow the gate alone, one i_clk late
   always_comb begin
      oe_next = {DATA_W{~i_out_gate_b}};
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         oe_reg <= '0;
      end else begin
         oe_reg <= oe_next;
      end
   end

   assign o_data_pins       = out_reg;
   assign o_data_pins_oe    = oe_reg;
   assign o_scan_serial_out = sdo_reg;
endmodule
`default_nettype wire

// ### tb/srr_rom_props.sv
// Port checks for the shadow-registered memory
`default_nettype none
module srr_rom_props import srr_pkg::*; (
   input wire logic              i_clk, i_rst_b, i_mode, i_output_load_clock, i_shadow_shift_clock,
   input wire logic              i_scan_serial_in, i_out_gate_b, o_scan_serial_out,
   input wire logic [ADDR_W-1:0] i_word_select,
   input wire logic [DATA_W-1:0] o_data_pins, o_data_pins_oe
);
   logic       oq, sq;
   logic [3:0] sh;
   logic [2:0] n;
   wire logic  oed = i_output_load_clock & ~oq;
   wire logic  sed = i_shadow_shift_clock & ~sq;
   // Count of back-to-back shifts; after four the shadow content is known
   always_ff @(posedge i_clk or negedge i_rst_b)
      if (!i_rst_b) {oq, sq, sh, n} <= '0;
      else begin
         {oq, sq} <= {i_output_load_clock, i_shadow_shift_clock};
         if (sed) n <= i_mode ? 3'h0 : n + {2'h0, n < 3'h4};
         if (sed && !i_mode) sh <= {sh[2:0], i_scan_serial_in};
      end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   a_out_hold: assert property (!oed |=> $stable(o_data_pins)) else $error("out moved");
   a_oe_gate: assert property (1 |=> o_data_pins_oe == {4{!$past(i_out_gate_b)}}) else $error("oe");
   a_oe_whole: assert property (o_data_pins_oe inside {4'h0, 4'hf}) else $error("oe split");
   a_sdo_pass: assert property (i_mode |=> o_scan_serial_out == $past(i_scan_serial_in)) else $error("pass");
   a_sdo_still: assert property (!i_mode && !$past(i_mode) && !sed |=> $stable(o_scan_serial_out))
      else $error("sdo moved");
   a_sdo_shift: assert property (n == 3'h4 && !i_mode && !sed |=> o_scan_serial_out == $past(sh[3]))
      else $error("sdo");
   a_ctrl_load: assert property (oed && i_mode && n == 3'h4 |=> o_data_pins == $past(sh)) else $error("ctl");
   a_blank_read: assert property (oed && !i_mode && i_word_select == 12'h0 && $past(i_word_select) == 12'h0
      |=> o_data_pins == BLANK_WORD) else $error("blank");
   c_ctrl: cover property (oed && i_mode);
   c_shift: cover property (sed && !i_mode);
   c_full: cover property (n == 3'h4);
endmodule
bind srr_rom srr_rom_props i_srr_rom_props (.*);
`default_nettype wire

// ### tb/srr_bus_model.sv
// Far side of the data pins: the block or outside logic drives them
`default_nettype none
module srr_bus_model (
   input  wire logic [3:0] i_dq, i_oe, i_ext,
   input  wire logic       i_ext_en,
   output logic      [3:0] o_pins
);
   timeunit 1ns; timeprecision 1ns;
   logic [3:0] last = 4'h0;
   // A released bus shows the inverse of its last level, never a held value
   always_comb o_pins = |i_oe ? i_dq : i_ext_en ? i_ext : ~last;
   always @(o_pins) if (|i_oe || i_ext_en) last = o_pins;
endmodule
`default_nettype wire

// ### tb/srr_rom_tb.sv
// Testbench for the shadow-registered memory
`default_nettype none
module srr_rom_tb import srr_pkg::*;;
   timeunit 1ns; timeprecision 1ns;
   logic i_clk = 0, i_rst_b = 0, i_mode = 0, i_output_load_clock = 0, i_shadow_shift_clock = 0, ext_en = 0;
   logic i_scan_serial_in = 0, i_out_gate_b = 1, i_prog_en = 0, o_scan_serial_out;
   logic [ADDR_W-1:0] i_word_select = 0, i_prog_addr = 0;
   logic [DATA_W-1:0] i_prog_bits = 0, ext = 0, i_data_pins, o_data_pins, o_data_pins_oe;
   int error_cnt = 0, compares = 0;
   srr_rom i_srr_rom (.*);
   srr_bus_model i_srr_bus_model (.i_dq(o_data_pins), .i_oe(o_data_pins_oe), .i_ext(ext), .i_ext_en(ext_en),
      .o_pins(i_data_pins));
   always #10 i_clk = ~i_clk;
   task chk(input string nm, input logic [3:0] s, e);
      compares++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %s exp %h got %h", nm, e, s);
      end
   endtask
   task give_verdict;
      if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Address and mode settle two cycles before the clock rises
   task pulse(input bit s);
      repeat (2) @(negedge i_clk);
      if (s) i_shadow_shift_clock = 1; else i_output_load_clock = 1;
      repeat (2) @(negedge i_clk);
      {i_shadow_shift_clock, i_output_load_clock} = 2'h0;
      @(negedge i_clk);
   endtask
   task t_control;
      logic [3:0] d = 4'ha;
      for (int i = 3; i >= 0; i--) begin
         i_scan_serial_in = d[i];
         pulse(1);
      end
      chk("held", o_data_pins, 4'h0);
      i_mode = 1;
      pulse(0);
      chk("control", o_data_pins, d);
   endtask
   task t_observe;
      logic [3:0] w = 4'h7;
      {i_prog_addr, i_prog_bits, i_prog_en} = {12'h5a3, 4'h6, 1'b1};
      @(negedge i_clk);
      {i_prog_bits, i_mode} = {4'h1, 1'b0};
      @(negedge i_clk);
      i_prog_en = 0;
      pulse(0);
      chk("blank", o_data_pins, BLANK_WORD);
      i_word_select = 12'h5a3;
      pulse(0);
      chk("word", o_data_pins, w);
      {i_out_gate_b, i_mode, i_scan_serial_in} = 3'b010;
      pulse(1);
      chk("driven", o_data_pins_oe, 4'hf);
      i_mode = 0;
      for (int i = 3; i >= 0; i--) begin
         @(negedge i_clk);
         chk("scan", {3'h0, o_scan_serial_out}, {3'h0, w[i]});
         pulse(1);
      end
   endtask
   task t_float;
      {i_out_gate_b, ext_en, ext, i_mode, i_scan_serial_in} = {2'b11, 4'h9, 2'b11};
      @(negedge i_clk);
      chk("released", o_data_pins_oe, 4'h0);
      chk("pass", {3'h0, o_scan_serial_out}, 4'h1);
      i_scan_serial_in = 0;
      pulse(1);
      {i_scan_serial_in, ext} = {1'b1, 4'h0};
      pulse(1);
      pulse(0);
      chk("outside", o_data_pins, 4'h9);
   endtask
   initial begin
      repeat (4) @(negedge i_clk);
      i_rst_b = 1;
      t_control;
      t_observe;
      t_float;
      give_verdict;
   end
   initial begin
      #100us;
      error_cnt++;
      give_verdict;
   end
endmodule
`default_nettype wire
